// ---- src/adc_clk_pkg.sv ----
// constants and types for the sample time and conversion clock control
// assumes an apb slave on pclk at 200 MHz and a sequencer that consumes it
// Operation
// - unimplemented bits 15-13 and bit 6 of the control register read 0.
// - automatic sampling lasts the sample time field in clock periods.
// - source select high picks the internal rc clock, low the derived one.
// - derived period is half an instruction cycle times divider plus one.
package adc_clk_pkg;
  localparam logic [11:0] ctrl_offset      = 12'h000;
  localparam logic [11:0] status_offset    = 12'h004;
  localparam logic [11:0] sample_offset    = 12'h008;
  localparam logic [15:0] ctrl_reset       = 16'h0000;
  localparam logic [15:0] ctrl_write_mask  = 16'h1FBF;
  localparam int          samp_lsb         = 8;
  localparam int          src_bit          = 7;
  localparam int          div_lsb          = 0;
  // half an instruction cycle lasts this many pclk cycles; one divider tick
  localparam int          half_cycle_clks  = 2;

  typedef struct packed {
    logic [4:0] auto_sample_periods;
    logic       conv_clock_source_sel;
    logic [5:0] conv_clock_divider;
  } ctrl_fields_type;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_sample = 3'b010,
    st_done   = 3'b100
  } samp_state_type;
endpackage

// ---- src/conv_clock_gen.sv ----
// conversion clock period generator: emits one pulse per period
// assumes rc_tick is a one-cycle pulse, one per rc oscillator period
`timescale 1ns/1ps
module conv_clock_gen
  import adc_clk_pkg::*;
(
  input  wire logic       pclk,         // system clock
  input  wire logic       presetn,      // async reset, active low
  input  wire logic       src_rc,       // 1 selects rc oscillator
  input  wire logic [5:0] divider,      // derived clock divider field
  input  wire logic       rc_tick,      // rc oscillator period pulse
  output logic            period_pulse  // one pulse per conversion period
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [3:0] pre_r;
  logic [3:0] pre_nxt;
  logic       tick;
  logic       cnt_wrap;
  logic       derived_pulse;
  logic [8:0] gap_r;
  logic [5:0] div_seen_r;
  logic       gap_ok_r;
  logic [8:0] period_len;

  default clocking cb_pclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // half-cycle ticks
  // one tick per half instruction cycle, half_cycle_clks pclk cycles long
  assign tick     = pre_r == 4'(half_cycle_clks - 1);
  assign pre_nxt  = tick ? 4'h0 : pre_r + 4'h1;
  // >= lets a lowered divider take effect without a 64-tick wrap
  assign cnt_wrap = tick && (cnt_r >= divider);
  assign cnt_nxt  = !tick ? cnt_r : (cnt_wrap ? 6'h00 : cnt_r + 6'h01);
  assign derived_pulse = cnt_wrap;

  assign period_pulse = src_rc ? rc_tick : derived_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
      pre_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
    end
  end

  // checker state: cycles since the last derived pulse, and whether the
  // divider stayed put over that whole period
  assign period_len = ({3'h0, divider} + 9'h001) * 9'(half_cycle_clks);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r      <= 9'h000;
      div_seen_r <= 6'h00;
      gap_ok_r   <= 1'b0;
    end else if (derived_pulse) begin
      gap_r      <= 9'h001;
      div_seen_r <= divider;
      gap_ok_r   <= 1'b1;
    end else begin
      gap_r      <= gap_r + 9'h001;
      gap_ok_r   <= gap_ok_r && (divider == div_seen_r);
    end
  end

  a_derived_period: assert property (
    derived_pulse && gap_ok_r && divider == div_seen_r |->
      gap_r == period_len)
    else $error("derived period wrong");

  a_rc_select: assert property (
    src_rc |-> period_pulse == rc_tick)
    else $error("rc clock not used");
endmodule

// ---- src/adc_sample_clock_config.sv ----
// apb register slave and automatic sample timer
// assumes a standard apb master; the sequencer pulses sample_start
// and waits for sample_done before it starts the next sample
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module adc_sample_clock_config
  import adc_clk_pkg::*;
(
  input  wire logic        pclk,          // system clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        rc_tick,       // rc oscillator period pulse
  input  wire logic        sample_start,  // sequencer starts sampling
  output logic             sampling,      // auto-sample in progress
  output logic             sample_done,   // pulse at end of sampling
  output logic             period_pulse,  // conversion clock period
  output ctrl_fields_type  fields         // fields to the sequencer
);
  logic [15:0]    ctrl_r;
  logic [15:0]    ctrl_nxt;
  samp_state_type state_r;
  samp_state_type state_nxt;
  logic [4:0]     samp_cnt_r;
  logic [4:0]     samp_cnt_nxt;
  logic [31:0]    prdata_r;
  logic [31:0]    rd_mux;
  logic           wr_en;
  logic           rd_en;
  logic           hit_ctrl;
  logic           hit_stat;
  logic           hit_samp;
  logic           unmapped;
  logic           samp_end;

  // every assertion below runs on pclk and sleeps through reset
  default clocking cb_pclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // one aligned word per register, so the whole byte address is compared
  function automatic logic addr_hit(input logic [11:0] addr,
                                    input logic [11:0] offset);
    return addr == offset;
  endfunction

  // zero wait states: every access finishes in its first access cycle
  assign pready   = 1'b1;
  assign hit_ctrl = addr_hit(paddr, ctrl_offset);
  assign hit_stat = addr_hit(paddr, status_offset);
  assign hit_samp = addr_hit(paddr, sample_offset);
  assign unmapped = !(hit_ctrl || hit_stat || hit_samp);
  assign wr_en    = psel && penable && pwrite;
  // read data is captured in the setup cycle, so it stands through the
  // whole access phase without a path from paddr to prdata
  assign rd_en    = psel && !penable && !pwrite;
  // unmapped places answer with an error; a write to them is dropped
  assign pslverr  = psel && penable && unmapped;

  assign ctrl_nxt = (wr_en && hit_ctrl) ? (pwdata[15:0] & ctrl_write_mask)
                                        : ctrl_r;

  // the sequencer sees the fields straight from the register, no shadow
  assign fields.auto_sample_periods   = ctrl_r[samp_lsb +: 5];
  assign fields.conv_clock_source_sel = ctrl_r[src_bit];
  assign fields.conv_clock_divider    = ctrl_r[div_lsb +: 6];

  // status shows the one-hot sampler state, for software polling
  assign rd_mux = hit_ctrl ? {16'h0000, ctrl_r} :
                  hit_stat ? {29'h0, state_r} :
                  hit_samp ? {27'h0, samp_cnt_r} : 32'h0000_0000;
  assign prdata = prdata_r;

  // the divided clock runs all the time, so a source switch never waits
  // for the divider to restart
  conv_clock_gen u_conv_clock_gen (
    .pclk         (pclk),
    .presetn      (presetn),
    .src_rc       (fields.conv_clock_source_sel),
    .divider      (fields.conv_clock_divider),
    .rc_tick      (rc_tick),
    .period_pulse (period_pulse)
  );

  // sample lasts field periods; counted on selected clock
  // a zero field ends sampling at once, legal only for multi-amp sequences
  // >= so that a field lowered mid-sample ends it instead of wrapping
  assign samp_end = (samp_cnt_r >= fields.auto_sample_periods) ||
                    (period_pulse &&
                     samp_cnt_r + 5'h01 >= fields.auto_sample_periods);

  // idle keeps the counter cleared, so a start always counts from zero
  always_comb begin
    state_nxt    = state_r;
    samp_cnt_nxt = samp_cnt_r;
    unique case (state_r)
      st_idle: begin
        samp_cnt_nxt = 5'h00;
        if (sample_start) begin
          state_nxt = st_sample;
        end
      end
      st_sample: begin
        if (samp_end) begin
          state_nxt = st_done;
        end else if (period_pulse) begin
          samp_cnt_nxt = samp_cnt_r + 5'h01;
        end
      end
      st_done: begin
        state_nxt = st_idle;
      end
      default: begin
        state_nxt = st_idle;
      end
    endcase
  end

  // both decode the state register, so neither output can glitch
  assign sampling    = state_r == st_sample;
  assign sample_done = state_r == st_done;

  // the read data register only loads in a read setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= ctrl_reset;
      state_r    <= st_idle;
      samp_cnt_r <= 5'h00;
      prdata_r   <= 32'h0000_0000;
    end else begin
      ctrl_r     <= ctrl_nxt;
      state_r    <= state_nxt;
      samp_cnt_r <= samp_cnt_nxt;
      prdata_r   <= rd_en ? rd_mux : prdata_r;
    end
  end

  sequence s_sample_begin;
    state_r == st_idle && sample_start;
  endsequence

  sequence s_last_period;
    sampling && period_pulse &&
      samp_cnt_r + 5'h01 >= fields.auto_sample_periods;
  endsequence

  a_reserved_zero: assert property (
    ctrl_r[15:13] == 3'h0 && ctrl_r[6] == 1'b0)
    else $error("reserved bits set");

  a_write_ctrl: assert property (
    wr_en && hit_ctrl |=>
      ctrl_r == ($past(pwdata) & {16'h0000, ctrl_write_mask}))
    else $error("ctrl write lost");

  a_read_ctrl: assert property (
    rd_en && hit_ctrl |=>
      prdata[31:13] == 19'h00000 && prdata[6] == 1'b0)
    else $error("reserved read nonzero");

  a_field_source: assert property (
    fields.conv_clock_source_sel == ctrl_r[src_bit])
    else $error("source field wrong");

  a_sample_start: assert property (
    s_sample_begin |=> sampling)
    else $error("sampling did not start");

  a_start_count: assert property (
    s_sample_begin |=> samp_cnt_r == 5'h00)
    else $error("count not cleared at start");

  a_sample_hold: assert property (
    sampling && !samp_end |=> sampling)
    else $error("sampling ended early");

  a_sample_count: assert property (
    sampling && !period_pulse && !samp_end |=> $stable(samp_cnt_r))
    else $error("count moved without period");

  a_count_step: assert property (
    sampling && period_pulse && !samp_end |=>
      samp_cnt_r == $past(samp_cnt_r) + 5'h01)
    else $error("count missed a period");

  a_rc_count: assert property (
    sampling && fields.conv_clock_source_sel && rc_tick && !samp_end |=>
      samp_cnt_r != $past(samp_cnt_r))
    else $error("rc period not counted");

  a_sample_end: assert property (
    sampling && samp_cnt_r >= fields.auto_sample_periods |=> sample_done)
    else $error("sampling overran");

  a_last_period: assert property (
    s_last_period |=> sample_done)
    else $error("sampling missed last period");

  a_zero_sample: assert property (
    sampling && fields.auto_sample_periods == 5'h00 |=> !sampling)
    else $error("zero sample time not immediate");

  a_done_pulse: assert property (
    sample_done |=> !sample_done && state_r == st_idle)
    else $error("done not a pulse");
endmodule

// ---- tb/adc_sample_clock_config_test.sv ----
// self-checking bench for the sample time and conversion clock control
// assumes the apb slave answers with pready and rc_tick is a free pulse
`timescale 1ns/1ps
module adc_sample_clock_config_test;
  import adc_clk_pkg::*;
  logic            pclk         = 1'b0;
  logic            presetn      = 1'b0;
  logic            psel         = 1'b0;
  logic            penable      = 1'b0;
  logic            pwrite       = 1'b0;
  logic            rc_tick      = 1'b0;
  logic            sample_start = 1'b0;
  logic     [11:0] paddr        = 12'h000;
  logic     [31:0] pwdata       = 32'h0000_0000;
  wire logic [31:0] prdata;
  wire logic       pready;
  wire logic       pslverr;
  wire logic       sampling;
  wire logic       sample_done;
  wire logic       period_pulse;
  ctrl_fields_type fields;
  int              bad_count    = 0;
  int              n_compared   = 0;
  int              cycles       = 0;
  int              cnt          = 0;
  int              seed         = 32'hDC59A573;
  int              n;
  int              k;
  logic     [15:0] v;
  logic     [32:0] rq[$];
  logic     [32:0] sq[$];

  adc_sample_clock_config u_adc_sample_clock_config (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
    .sample_start(sample_start), .sampling(sampling),
    .sample_done(sample_done), .period_pulse(period_pulse), .fields(fields)
  );

  task automatic wrap_up;
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // the rc oscillator runs free, so its ticks come at random spacing
  always @(posedge pclk) rc_tick <= ($random(seed) & 3) == 0;

  // monitor: reads and sampling windows are matched against the notes
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up;
    end
    if (psel && penable && pready && !pwrite && rq.size() > 0)
      check({pslverr, prdata}, rq.pop_front());
    if (sampling === 1'b1 && period_pulse === 1'b1) cnt++;
    if (sample_done === 1'b1 && sq.size() > 0) begin
      check(cnt, sq.pop_front());
      cnt = 0;
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rq.push_back({17'h0, ctrl_reset});
    apb(1'b0, ctrl_offset, 32'h0);
    // status is the one-hot state, idle after reset; the count starts at 0
    rq.push_back({1'b0, 32'h0000_0001});
    apb(1'b0, status_offset, 32'h0);
    rq.push_back({1'b0, 32'h0000_0000});
    apb(1'b0, sample_offset, 32'h0);
    for (n = 0; n < 6; n++) begin
      v = $random(seed);
      if (v[12:8] == 5'h00) v[12:8] = 5'h01;
      // a divider of 56 to 63 on pass 4, an even pass, where the derived clock is used
      v[5:0] = {3'h0, v[2:0]} + ((n == 4) ? 6'h38 : 6'h00);
      v[7] = n[0];
      apb(1'b1, ctrl_offset, {16'hFFFF, v});
      rq.push_back({17'h0, v & ctrl_write_mask});
      apb(1'b0, ctrl_offset, 32'h0);
      check(fields, {v[12:8], v[7], v[5:0]});
      if (!v[7]) begin
        @(posedge pclk iff period_pulse === 1'b1);
        k = 0;
        do begin @(posedge pclk); k++; end while (period_pulse !== 1'b1);
        check(k, half_cycle_clks * (v[5:0] + 1));
      end else begin
        @(posedge pclk); #1;
        check(period_pulse, rc_tick);
      end
      sq.push_back(v[12:8]);
      @(posedge pclk); sample_start <= 1'b1;
      @(posedge pclk); sample_start <= 1'b0;
      @(posedge pclk iff sample_done === 1'b1);
    end
    // unmapped place: error, reads zero, write has no effect
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    rq.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h0FC, 32'h0);
    rq.push_back({17'h0, v & ctrl_write_mask});
    apb(1'b0, ctrl_offset, 32'h0);
    @(posedge pclk);
    wrap_up;
  end
endmodule
